// file: dv/seo_supply_model.sv
`timescale 1ns/1ps
module seo_supply_model (
   input wire logic [11:0] en_out_i,
   input wire logic [11:0] en_oe_n_i,
   input wire logic rst_out_i,
   input wire logic rst_oe_n_i,
   input wire logic wdo_out_i,
   input wire logic wdo_oe_n_i,
   output logic [11:0] en_line_o,
   output logic rst_line_o,
   output logic wdo_line_o
);
   // Each line has a pull-up, so a released pin reads high and never the last value.
   // open-drain pull-up
   assign wdo_line_o = wdo_oe_n_i ? 1'b1 : wdo_out_i;
   assign rst_line_o = rst_oe_n_i ? 1'b1 : rst_out_i;
   assign en_line_o = (en_out_i & ~en_oe_n_i) | en_oe_n_i;
endmodule

// file: dv/seo_top_checker.sv
`timescale 1ns/1ps
module seo_top_checker #(
   parameter int NUM_OUTPUTS = 12,
   parameter int unsigned TMO_BASE_CYC = 625
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   input wire logic seq_reset_req_i,
   input wire logic wd_expired_i,
   input wire logic pin_four_is_mr_i,
   input wire logic general_pin_four_i,
   input wire logic general_pin_five_i,
   input wire logic general_pin_six_o,
   input wire logic general_pin_six_oe_n_o,
   input wire logic watchdog_kick_in_o,
   input wire logic watchdog_kick_sel_o,
   input wire logic reset_out_oe_n_o,
   input wire logic reset_active_o,
   input wire logic [11:0] en_out_o,
   input wire logic [11:0] en_out_oe_n_o,
   input wire logic [3:0] track_drive_o,
   input wire logic [5:0] pump_drive_o,
   input wire logic [11:0] mode_reserved_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   a_mr_holds_reset: assert property (
      (pin_four_is_mr_i && !general_pin_four_i)[*4] |=> !reset_out_oe_n_o && reset_active_o)
      else $error("manual reset low did not hold the reset output");
   a_reset_source: assert property ($fell(reset_out_oe_n_o) |->
      $past(seq_reset_req_i) || $past(seq_reset_req_i, 2)
      || (!$past(general_pin_four_i, 4) && $past(pin_four_is_mr_i, 4)))
      else $error("reset output asserted without a cause");
   a_stretch_min: assert property (
      $rose(reset_out_oe_n_o) && pin_four_is_mr_i |-> $past(general_pin_four_i, 6))
      else $error("reset released before the stretch elapsed");
   a_wdo_open_drain: assert property (
      !general_pin_six_oe_n_o |-> $past(wd_expired_i) && !general_pin_six_o)
      else $error("watchdog output driven without expiry or driven high");
   a_kick_follows: assert property (
      watchdog_kick_in_o == (watchdog_kick_sel_o && $past(general_pin_five_i, 3)))
      else $error("watchdog input path wrong");
   a_track_floats: assert property (
      (en_out_oe_n_o[3:0] & track_drive_o) == track_drive_o)
      else $error("tracking output also driven as plain enable");
   a_pump_floats: assert property (
      (en_out_oe_n_o[5:0] & pump_drive_o) == pump_drive_o)
      else $error("charge-pump output also driven as plain enable");
   a_reserved_safe: assert property (
      (en_out_oe_n_o & mode_reserved_o) == mode_reserved_o
      && (en_out_o & mode_reserved_o) == 12'h000 && (track_drive_o & mode_reserved_o[3:0]) == 4'h0)
      else $error("reserved output not released");
endmodule

bind seo_top seo_top_checker #(.NUM_OUTPUTS(NUM_OUTPUTS), .TMO_BASE_CYC(TMO_BASE_CYC)) u_chk (
   .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .seq_reset_req_i(seq_reset_req_i),
   .wd_expired_i(wd_expired_i), .pin_four_is_mr_i(pin_four_is_mr_i),
   .general_pin_four_i(general_pin_four_i), .general_pin_five_i(general_pin_five_i),
   .general_pin_six_o(general_pin_six_o), .general_pin_six_oe_n_o(general_pin_six_oe_n_o),
   .watchdog_kick_in_o(watchdog_kick_in_o), .watchdog_kick_sel_o(watchdog_kick_sel_o),
   .reset_out_oe_n_o(reset_out_oe_n_o), .reset_active_o(reset_active_o),
   .en_out_o(en_out_o), .en_out_oe_n_o(en_out_oe_n_o), .track_drive_o(track_drive_o),
   .pump_drive_o(pump_drive_o), .mode_reserved_o(mode_reserved_o));

// file: dv/seo_top_tb.sv
`timescale 1ns/1ps
module seo_top_tb;
   import seo_pkg::*;
   localparam int TB = 4;
   logic clk_sys_i, reset_n_i, reg_wr_i, reg_rd_i, reg_rvalid_o, seq_reset_req_i, wd_expired_i;
   logic pin_four_is_mr_i, general_pin_four_i, general_pin_five_i, general_pin_six_o;
   logic general_pin_six_oe_n_o, watchdog_kick_in_o, watchdog_kick_sel_o, reset_out_o;
   logic reset_out_oe_n_o, reset_active_o, rst_line, wdo_line;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
   logic [11:0] en_req_i, en_out_o, en_out_oe_n_o, mode_reserved_o, en_line, el, eo, er;
   logic [3:0] track_drive_o, et;
   logic [5:0] pump_drive_o, ep;
   logic [31:0] cfg;
   logic [4:0] e;
   logic [2:0] k [12];
   logic [11:0] pats [3] = '{12'h000, 12'hFFF, 12'hA5A};
   int n_errors = 0;
   int total_checks = 0;
   int cyc = 0;

   seo_top #(.NUM_OUTPUTS(12), .TMO_BASE_CYC(TB)) u_dut (
      .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
      .reg_rvalid_o(reg_rvalid_o), .en_req_i(en_req_i), .seq_reset_req_i(seq_reset_req_i),
      .wd_expired_i(wd_expired_i), .pin_four_is_mr_i(pin_four_is_mr_i),
      .general_pin_four_i(general_pin_four_i), .general_pin_five_i(general_pin_five_i),
      .general_pin_six_o(general_pin_six_o), .general_pin_six_oe_n_o(general_pin_six_oe_n_o),
      .watchdog_kick_in_o(watchdog_kick_in_o), .watchdog_kick_sel_o(watchdog_kick_sel_o),
      .reset_out_o(reset_out_o), .reset_out_oe_n_o(reset_out_oe_n_o),
      .reset_active_o(reset_active_o), .en_out_o(en_out_o), .en_out_oe_n_o(en_out_oe_n_o),
      .track_drive_o(track_drive_o), .pump_drive_o(pump_drive_o),
      .mode_reserved_o(mode_reserved_o));

   seo_supply_model u_load (
      .en_out_i(en_out_o), .en_oe_n_i(en_out_oe_n_o), .rst_out_i(reset_out_o),
      .rst_oe_n_i(reset_out_oe_n_o), .wdo_out_i(general_pin_six_o),
      .wdo_oe_n_i(general_pin_six_oe_n_o), .en_line_o(en_line), .rst_line_o(rst_line),
      .wdo_line_o(wdo_line));

   initial begin
      clk_sys_i = 1'b0;
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      cyc++;
      if (cyc > 20000) begin
         n_errors++;
         report_and_stop();
      end
   end

   // ----------------------------------------------------------------------
   // Access and compare tasks
   // ----------------------------------------------------------------------
   task automatic report_and_stop();
      if (n_errors == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk_pins(input logic [11:0] got, exp, input string m);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, d);
      reg_addr_i = a;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      @(negedge clk_sys_i);
      reg_wr_i = 1'b0;
      @(negedge clk_sys_i);
   endtask

   task automatic chk_reg(input logic [7:0] a, exp);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      @(negedge clk_sys_i);
      reg_rd_i = 1'b0;
      total_checks++;
      if (reg_rvalid_o !== 1'b1 || reg_rdata_o !== exp) begin
         n_errors++;
         $display("unexpected at %0t: read %h got %h expected %h", $time, a, reg_rdata_o, exp);
      end
      @(negedge clk_sys_i);
   endtask

   // Releases the pin after a low spell and counts cycles until the reset line rises.
   task automatic mr_run(input logic [2:0] sel, input logic en, input int exp_n);
      int n;
      wr(8'h19, {1'b0, sel, 4'h0});
      pin_four_is_mr_i = en;
      general_pin_four_i = 1'b0;
      repeat (8) @(negedge clk_sys_i);
      chk_pins(12'({rst_line, reset_active_o}), 12'({!en, en}), "reset while pin low");
      general_pin_four_i = 1'b1;
      n = 0;
      while (rst_line !== 1'b1 && n < 5000) begin
         @(negedge clk_sys_i);
         n++;
      end
      chk_pins(12'(n), 12'(exp_n), "stretch length");
   endtask

   // Result order is line level, drive enable, tracking, pump, reserved.
   function automatic logic [4:0] exp_out(int i, logic [2:0] c, logic r);
      if (c[2] && (c[1] || (c[0] ? i > 5 : i > 3))) return 5'b11001;
      case (c)
         3'b000: return {!r, !r, 3'b000};
         3'b001: return {r, r, 3'b000};
         3'b010: return {!r, 1'b0, 3'b000};
         3'b011: return {r, 1'b0, 3'b000};
         3'b100: return {2'b11, r, 2'b00};
         default: return {2'b11, 1'b0, r, 1'b0};
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------------------
   initial begin
      reset_n_i = 1'b0;
      {reg_wr_i, reg_rd_i, seq_reset_req_i, wd_expired_i, pin_four_is_mr_i} = 5'h00;
      {general_pin_four_i, general_pin_five_i, reg_addr_i, reg_wdata_i} = 18'h20000;
      en_req_i = 12'h000;
      repeat (2) @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      @(negedge clk_sys_i);
      chk_reg(8'h30, 8'h00);
      for (int c = 0; c < 8; c++) begin
         cfg = 32'hC000_0000;
         for (int i = 0; i < 12; i++) begin
            k[i] = (i < 6) ? 3'(c + i) : {1'b0, 2'(c + i)};
            cfg |= (i < 6) ? (32'(k[i]) << (3 * i)) : (32'(k[i]) << (6 + 2 * i));
         end
         for (int b = 0; b < 4; b++) wr(8'h1F + 8'(b), cfg[8*b +: 8]);
         for (int b = 0; b < 4; b++) chk_reg(8'h1F + 8'(b), cfg[8*b +: 8] & {b != 3, b != 3, 6'h3F});
         for (int p = 0; p < 3; p++) begin
            en_req_i = pats[p];
            repeat (2) @(negedge clk_sys_i);
            for (int i = 0; i < 12; i++) begin
               e = exp_out(i, k[i], pats[p][i]);
               {el[i], eo[i], er[i]} = {e[4], e[3], e[0]};
               if (i < 4) et[i] = e[2];
               if (i < 6) ep[i] = e[1];
            end
            chk_pins(en_line, el, "enable line");
            chk_pins(en_out_oe_n_o, eo, "enable drive");
            chk_pins({8'h00, track_drive_o}, {8'h00, et}, "tracking");
            chk_pins({6'h00, pump_drive_o}, {6'h00, ep}, "pump");
            chk_pins(mode_reserved_o, er, "reserved");
         end
      end
      wr(8'h1E, 8'hFF);
      chk_reg(8'h1E, 8'h03);
      wr(8'h1D, 8'h70);
      chk_reg(8'h1D, 8'h70);
      {wd_expired_i, general_pin_five_i} = 2'b11;
      repeat (4) @(negedge clk_sys_i);
      chk_pins(12'(wdo_line), 12'h000, "watchdog line");
      chk_pins(12'({watchdog_kick_sel_o, watchdog_kick_in_o}), 12'h003, "kick");
      wr(8'h1D, 8'hE0);
      repeat (4) @(negedge clk_sys_i);
      chk_pins(12'(wdo_line), 12'h001, "watchdog line");
      chk_pins(12'({watchdog_kick_sel_o, watchdog_kick_in_o}), 12'h000, "kick");
      {wd_expired_i, general_pin_five_i} = 2'b00;
      // Two synchroniser stages and the registered reset pin add three cycles to the timeout.
      mr_run(3'd0, 1'b1, TB + 3);
      mr_run(3'd2, 1'b1, (TB << 2) + 3);
      mr_run(3'd7, 1'b1, (TB << 7) + 3);
      mr_run(3'd1, 1'b0, 0);
      reset_n_i = 1'b0;
      @(negedge clk_sys_i);
      reset_n_i = 1'b1;
      @(negedge clk_sys_i);
      chk_reg(8'h1F, 8'h00);
      report_and_stop();
   end
endmodule

// file: rtl/seo_pkg.sv
package seo_pkg;

   typedef enum logic [2:0] {
      SEO_MODE_OD_LOW = 3'b000,
      SEO_MODE_OD_HIGH = 3'b001,
      SEO_MODE_PP_LOW = 3'b010,
      SEO_MODE_PP_HIGH = 3'b011,
      SEO_MODE_TRACK = 3'b100,
      SEO_MODE_PUMP = 3'b101,
      SEO_MODE_RSV6 = 3'b110,
      SEO_MODE_RSV7 = 3'b111
   } seo_mode_t;

   typedef logic [2:0] seo_tmo_sel_t;

   typedef struct packed {
      logic pin_out;
      logic pin_oe_n;
      logic track;
      logic pump;
      logic rsv;
   } seo_drive_t;

endpackage

// file: rtl/seo_regs.svh
`ifndef SEO_REGS_SVH
`define SEO_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define SEO_ADDR_RST_TMO 8'h19
`define SEO_ADDR_WDI_CFG 8'h1D
`define SEO_ADDR_WDO_CFG 8'h1E
`define SEO_ADDR_CFG_A 8'h1F
`define SEO_ADDR_CFG_B 8'h20
`define SEO_ADDR_CFG_C 8'h21
`define SEO_ADDR_CFG_D 8'h22

// ----------------------------------------------------------------------
// Reset values and masks
// ----------------------------------------------------------------------
`define SEO_CFG_RESET 8'h00
`define SEO_CFG_D_WMASK 8'h3F
`define SEO_RST_TMO_MASK 8'h70
`define SEO_WDI_CFG_MASK 8'hF0
`define SEO_WDO_CFG_MASK 8'h03

// ----------------------------------------------------------------------
// Field positions and patterns
// ----------------------------------------------------------------------
`define SEO_TMO_LSB 4
`define SEO_WDI_LSB 4
`define SEO_WDO_LOW_BIT 7
`define SEO_WDO_PATTERN 3'h6
`define SEO_WDI_PATTERN 3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SEO_CLK_MHZ 25
`define SEO_TMO_BASE_US 25
`define SEO_TMO_BASE_CYC (`SEO_TMO_BASE_US * `SEO_CLK_MHZ)

`endif

// file: rtl/seo_reset_stretch.sv
`timescale 1ns/1ps
`include "seo_regs.svh"
module seo_reset_stretch #(
   parameter int unsigned TMO_BASE_CYC = `SEO_TMO_BASE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   seo_rst_if.stretch rst_if
);
   import seo_pkg::*;

   localparam int CW = $clog2(TMO_BASE_CYC * 128 + 1);

   logic [CW-1:0] cnt_reg;
   logic hold_reg;
   logic [CW-1:0] limit;

   // Timeout doubles with each step of the select field.
   // timeout from select
   assign limit = CW'(TMO_BASE_CYC) << rst_if.tmo_sel;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cnt_reg <= '0;
         hold_reg <= 1'b0;
      end else if (rst_if.mr_enable && !rst_if.mr_level) begin
         cnt_reg <= '0;
         hold_reg <= 1'b1;
      end else if (hold_reg) begin
         if (cnt_reg >= limit - CW'(1)) begin
            hold_reg <= 1'b0;
            cnt_reg <= '0;
         end else begin
            cnt_reg <= cnt_reg + CW'(1);
         end
      end
   end

   assign rst_if.rst_hold = hold_reg;
endmodule

// file: rtl/seo_rst_if.sv
`timescale 1ns/1ps
interface seo_rst_if;
   import seo_pkg::*;
   logic mr_enable;
   logic mr_level;
   seo_tmo_sel_t tmo_sel;
   logic rst_hold;

   modport main (output mr_enable, output mr_level, output tmo_sel, input rst_hold);
   modport stretch (input mr_enable, input mr_level, input tmo_sel, output rst_hold);
endinterface

// file: rtl/seo_top.sv
`timescale 1ns/1ps
`include "seo_regs.svh"
module seo_top #(
   parameter int NUM_OUTPUTS = 12,
   parameter int unsigned TMO_BASE_CYC = `SEO_TMO_BASE_CYC
) (
   input wire logic clk_sys_i,
   input wire logic reset_n_i,
   // Register port.
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic reg_rvalid_o,
   // Enable requests from the sequencer, one per output.
   input wire logic [11:0] en_req_i,
   // Reset request from the sequencer and watchdog expiry.
   input wire logic seq_reset_req_i,
   input wire logic wd_expired_i,
   // Pin function select for pin four.
   input wire logic pin_four_is_mr_i,
   // General pins.
   input wire logic general_pin_four_i,
   input wire logic general_pin_five_i,
   output logic general_pin_six_o,
   output logic general_pin_six_oe_n_o,
   output logic watchdog_kick_in_o,
   output logic watchdog_kick_sel_o,
   // Reset output pin, open-drain active-low.
   output logic reset_out_o,
   output logic reset_out_oe_n_o,
   output logic reset_active_o,
   // Enable output pins.
   output logic [11:0] en_out_o,
   output logic [11:0] en_out_oe_n_o,
   output logic [3:0] track_drive_o,
   output logic [5:0] pump_drive_o,
   output logic [11:0] mode_reserved_o
);
   import seo_pkg::*;

   // ----------------------------------------------------------------------
   // Configuration registers
   // ----------------------------------------------------------------------
   logic [7:0] cfg_a_reg;
   logic [7:0] cfg_b_reg;
   logic [7:0] cfg_c_reg;
   logic [7:0] cfg_d_reg;
   logic [7:0] rst_tmo_reg;
   logic [7:0] wdi_cfg_reg;
   logic [7:0] wdo_cfg_reg;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         cfg_a_reg <= `SEO_CFG_RESET;
         cfg_b_reg <= `SEO_CFG_RESET;
         cfg_c_reg <= `SEO_CFG_RESET;
         cfg_d_reg <= `SEO_CFG_RESET;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            `SEO_ADDR_CFG_A: begin
               cfg_a_reg <= reg_wdata_i;
            end
            `SEO_ADDR_CFG_B: begin
               cfg_b_reg <= reg_wdata_i;
            end
            `SEO_ADDR_CFG_C: begin
               cfg_c_reg <= reg_wdata_i;
            end
            `SEO_ADDR_CFG_D: begin
               cfg_d_reg <= reg_wdata_i & `SEO_CFG_D_WMASK;
            end
            default: begin
            end
         endcase
      end
   end

   // Only the fields used here are stored; other bits read as zero.
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_tmo_reg <= `SEO_CFG_RESET;
         wdi_cfg_reg <= `SEO_CFG_RESET;
         wdo_cfg_reg <= `SEO_CFG_RESET;
      end else if (reg_wr_i) begin
         unique case (reg_addr_i)
            `SEO_ADDR_RST_TMO: begin
               rst_tmo_reg <= reg_wdata_i & `SEO_RST_TMO_MASK;
            end
            `SEO_ADDR_WDI_CFG: begin
               wdi_cfg_reg <= reg_wdata_i & `SEO_WDI_CFG_MASK;
            end
            `SEO_ADDR_WDO_CFG: begin
               wdo_cfg_reg <= reg_wdata_i & `SEO_WDO_CFG_MASK;
            end
            default: begin
            end
         endcase
      end
   end

   // ----------------------------------------------------------------------
   // Read back
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= 8'h00;
         reg_rvalid_o <= 1'b0;
      end else begin
         reg_rvalid_o <= reg_rd_i;
         if (reg_rd_i) begin
            unique case (reg_addr_i)
               `SEO_ADDR_CFG_A: begin
                  reg_rdata_o <= cfg_a_reg;
               end
               `SEO_ADDR_CFG_B: begin
                  reg_rdata_o <= cfg_b_reg;
               end
               `SEO_ADDR_CFG_C: begin
                  reg_rdata_o <= cfg_c_reg;
               end
               `SEO_ADDR_CFG_D: begin
                  reg_rdata_o <= cfg_d_reg;
               end
               `SEO_ADDR_RST_TMO: begin
                  reg_rdata_o <= rst_tmo_reg;
               end
               `SEO_ADDR_WDI_CFG: begin
                  reg_rdata_o <= wdi_cfg_reg;
               end
               `SEO_ADDR_WDO_CFG: begin
                  reg_rdata_o <= wdo_cfg_reg;
               end
               default: begin
                  reg_rdata_o <= 8'h00;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------------
   // Mode field extraction
   // ----------------------------------------------------------------------
   function automatic logic [2:0] chan_mode(input int idx, input logic [7:0] a,
                                            input logic [7:0] b, input logic [7:0] c,
                                            input logic [7:0] d);
      logic [2:0] m;
      m = 3'h0;
      unique case (idx)
         0: m = a[2:0];
         1: m = a[5:3];
         2: m = {b[0], a[7:6]};
         3: m = b[3:1];
         4: m = b[6:4];
         5: m = {c[1:0], b[7]};
         6: m = {1'b0, c[3:2]};
         7: m = {1'b0, c[5:4]};
         8: m = {1'b0, c[7:6]};
         9: m = {1'b0, d[1:0]};
         10: m = {1'b0, d[3:2]};
         11: m = {1'b0, d[5:4]};
         default: m = SEO_MODE_RSV7;
      endcase
      return m;
   endfunction

   // ----------------------------------------------------------------------
   // Pin drive decode
   // ----------------------------------------------------------------------
   function automatic seo_drive_t chan_drive(input int idx, input logic [2:0] code,
                                             input logic req);
      seo_drive_t dr;
      seo_mode_t m;
      dr = '{pin_out: 1'b0, pin_oe_n: 1'b1, track: 1'b0, pump: 1'b0, rsv: 1'b0};
      m = seo_mode_t'(code);
      unique case (m)
         SEO_MODE_OD_LOW: dr.pin_oe_n = !req;
         SEO_MODE_OD_HIGH: dr.pin_oe_n = req;
         SEO_MODE_PP_LOW: begin
            dr.pin_oe_n = 1'b0;
            dr.pin_out = !req;
         end
         SEO_MODE_PP_HIGH: begin
            dr.pin_oe_n = 1'b0;
            dr.pin_out = req;
         end
         SEO_MODE_TRACK: begin
            if (idx < 4) begin
               dr.track = req;
            end else begin
               dr.rsv = 1'b1;
            end
         end
         // charge pump on one to six
         SEO_MODE_PUMP: begin
            if (idx < 6) begin
               dr.pump = req;
            end else begin
               dr.rsv = 1'b1;
            end
         end
         SEO_MODE_RSV6, SEO_MODE_RSV7: dr.rsv = 1'b1;
      endcase
      if (dr.rsv || idx >= NUM_OUTPUTS) begin
         dr = '{pin_out: 1'b0, pin_oe_n: 1'b1, track: 1'b0, pump: 1'b0, rsv: 1'b1};
      end
      return dr;
   endfunction

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      seo_drive_t dr;
      if (!reset_n_i) begin
         en_out_o <= 12'h000;
         en_out_oe_n_o <= 12'hFFF;
         track_drive_o <= 4'h0;
         pump_drive_o <= 6'h00;
         mode_reserved_o <= 12'h000;
      end else begin
         for (int i = 0; i < 12; i++) begin
            dr = chan_drive(i, chan_mode(i, cfg_a_reg, cfg_b_reg, cfg_c_reg, cfg_d_reg),
                            en_req_i[i]);
            en_out_o[i] <= dr.pin_out;
            en_out_oe_n_o[i] <= dr.pin_oe_n;
            mode_reserved_o[i] <= dr.rsv;
            if (i < 4) begin
               track_drive_o[i] <= dr.track;
            end
            if (i < 6) begin
               pump_drive_o[i] <= dr.pump;
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------------
   logic [1:0] pin_four_sync_reg;
   logic [1:0] pin_five_sync_reg;

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         pin_four_sync_reg <= 2'h3;
         pin_five_sync_reg <= 2'h0;
      end else begin
         pin_four_sync_reg <= {pin_four_sync_reg[0], general_pin_four_i};
         pin_five_sync_reg <= {pin_five_sync_reg[0], general_pin_five_i};
      end
   end

   // ----------------------------------------------------------------------
   // Manual reset and reset output
   // ----------------------------------------------------------------------
   seo_rst_if rst_if ();

   assign rst_if.mr_enable = pin_four_is_mr_i;
   assign rst_if.mr_level = pin_four_sync_reg[1];
   assign rst_if.tmo_sel = rst_tmo_reg[`SEO_TMO_LSB +: 3];

   seo_reset_stretch #(
      .TMO_BASE_CYC(TMO_BASE_CYC)
   ) u_stretch (
      .clk_sys_i(clk_sys_i),
      .reset_n_i(reset_n_i),
      .rst_if(rst_if.stretch)
   );

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         reset_out_o <= 1'b0;
         reset_out_oe_n_o <= 1'b0;
         reset_active_o <= 1'b1;
      end else begin
         reset_out_o <= 1'b0;
         reset_out_oe_n_o <= !(rst_if.rst_hold || seq_reset_req_i);
         reset_active_o <= rst_if.rst_hold || seq_reset_req_i;
      end
   end

   // ----------------------------------------------------------------------
   // Watchdog pins
   // ----------------------------------------------------------------------
   logic wdo_sel;
   logic wdi_sel;

   assign wdo_sel = ({wdo_cfg_reg[1:0], wdi_cfg_reg[`SEO_WDO_LOW_BIT]} == `SEO_WDO_PATTERN);
   assign wdi_sel = (wdi_cfg_reg[`SEO_WDI_LSB +: 3] == `SEO_WDI_PATTERN);

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         general_pin_six_o <= 1'b0;
         general_pin_six_oe_n_o <= 1'b1;
         watchdog_kick_in_o <= 1'b0;
         watchdog_kick_sel_o <= 1'b0;
      end else begin
         general_pin_six_o <= 1'b0;
         general_pin_six_oe_n_o <= !(wdo_sel && wd_expired_i);
         watchdog_kick_in_o <= wdi_sel && pin_five_sync_reg[1];
         watchdog_kick_sel_o <= wdi_sel;
      end
   end
endmodule
